//--- src/ssc_pkg.sv
// Purpose: constants, types and helpers for the shutter/strobe/sync block
// Assumes: one 40 MHz clock, registers written over the 3-wire serial port
// Notes:   pattern shapes are fixed constants of this package

package ssc_pkg;

    // ****************************************
    // serial register port
    // ****************************************
    localparam int         SER_W     = 32;
    localparam int         ADDR_W    = 8;
    localparam int         DATA_W    = 24;
    localparam logic [5:0] SER_FULL  = 6'h20;

    localparam logic [7:0] ADDR_PAT    = 8'h01;
    localparam logic [7:0] ADDR_STROBE = 8'h0B;
    localparam logic [7:0] ADDR_SHUT   = 8'h0C;
    localparam logic [7:0] ADDR_LEN    = 8'h21;
    localparam logic [7:0] ADDR_SYNC   = 8'hD6;

    // ****************************************
    // field layout
    // ****************************************
    localparam int PAT_W      = 2;
    localparam int STROBE_BIT = 1;
    localparam int INIT_BIT   = 0;
    localparam int EN_BIT     = 1;
    localparam int POS_LSB    = 2;
    localparam int POS_W      = 11;
    localparam int FINE_LSB   = 13;
    localparam int FINE_W     = 3;
    localparam int LEN_W      = 8;
    localparam int SLAVE_BIT  = 0;
    localparam int HCNT_W     = 12;
    localparam int OL_W       = 12;

    localparam logic SLAVE_RST = 1'b1;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_HZ       = 40_000_000;
    localparam int HD_RST_CYC   = 7;
    localparam int SYNC_LAT_CYC = 3;
    localparam int HD_TAIL_CYC  = HD_RST_CYC - SYNC_LAT_CYC;
    localparam logic [2:0] HD_TAIL = 3'(HD_TAIL_CYC);

    localparam logic [HCNT_W-1:0] MST_LINE_CYC    = 12'h618;
    localparam logic [HCNT_W-1:0] MST_HD_W        = 12'h010;
    localparam logic [POS_W-1:0]  MST_FIELD_LINES = 11'h106;

    // ****************************************
    // synchronised pin vector
    // ****************************************
    localparam int         PIN_N     = 6;
    localparam int         PIN_SDATA = 0;
    localparam int         PIN_SCK   = 1;
    localparam int         PIN_SLD_N = 2;
    localparam int         PIN_HD    = 3;
    localparam int         PIN_VD    = 4;
    localparam int         PIN_VERTICAL_GATE_INPUT = 5;
    // idle pin levels: serial clock and data low, syncs high, gate low
    localparam logic [5:0] PIN_IDLE  = 6'h1C;

    typedef enum logic [1:0] {
        SH_ARMED = 2'b00,
        SH_RUN   = 2'b01,
        SH_DONE  = 2'b11
    } ssc_shut_e;

    // active part of a shutter pattern for line idx of len
    function automatic logic ssc_pat_on(input logic [PAT_W-1:0] sel,
                                        input logic [LEN_W-1:0] idx,
                                        input logic [LEN_W-1:0] len);
        logic [LEN_W-1:0] half;
        half = len >> 1;
        unique case (sel)
            2'h0: ssc_pat_on = 1'b1;
            2'h1: ssc_pat_on = (idx < half);
            2'h2: ssc_pat_on = (idx >= half);
            2'h3: ssc_pat_on = (idx != 8'h00);
        endcase
    endfunction

endpackage

//--- src/ssc_in_sync.sv
// Purpose: two-stage pin synchroniser with one extra delayed stage
// Assumes: inputs are asynchronous to clk_sys_i
// Notes:   stage one feeds stage two only; edges use stages two and three

`timescale 1ns/1ps
`default_nettype none

module ssc_in_sync
    import ssc_pkg::*;
#(
    parameter int         W   = PIN_N,
    parameter logic [W-1:0] RST = '1
) (
    // clock and reset
    input  wire logic         clk_sys_i,
    input  wire logic         resetn_i,
    // pins
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o,
    output logic      [W-1:0] q_dly_o
);

    logic [W-1:0] meta;

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            meta    <= RST;
            q_o     <= RST;
            q_dly_o <= RST;
        end else begin
            meta    <= d_i;
            q_o     <= meta;
            q_dly_o <= q_o;
        end
    end

endmodule

`default_nettype wire

//--- src/ssc_top.sv
// Purpose: mechanical shutter pulse, flash trigger and slave/master sync
// Assumes: substrate and sensor-gate pulses come from logic on clk_sys_i
// Notes:   registers are written only, over the 3-wire serial port

`timescale 1ns/1ps
`default_nettype none

module ssc_top
    import ssc_pkg::*;
(
    // clock and reset
    input  wire logic              clk_sys_i,
    input  wire logic              resetn_i,
    // serial register port
    input  wire logic              sdata_i,
    input  wire logic              sck_i,
    input  wire logic              sload_n_i,
    // sync pins
    input  wire logic              line_sync_i,
    output logic                   line_sync_o,
    output logic                   line_sync_oe_o,
    input  wire logic              field_sync_i,
    output logic                   field_sync_o,
    output logic                   field_sync_oe_o,
    input  wire logic              vertical_gate_input_i,
    // timing core events
    input  wire logic              substrate_clock_pulse_i,
    input  wire logic              substrate_clock_last_i,
    input  wire logic              sensor_gate_pulse_i,
    input  wire logic [OL_W-1:0]   sub_line_count_length_i,
    // outputs
    output logic                   mech_shutter_out_o,
    output logic                   flash_trigger_o,
    output logic [HCNT_W-1:0]      hcount_gray_o
);

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [PIN_N-1:0] pin_s;
    logic [PIN_N-1:0] pin_d;

    ssc_in_sync #(.W(PIN_N), .RST(PIN_IDLE)) u_sync (
        .clk_sys_i (clk_sys_i),
        .resetn_i  (resetn_i),
        .d_i       ({vertical_gate_input_i, field_sync_i, line_sync_i,
                     sload_n_i, sck_i, sdata_i}),
        .q_o       (pin_s),
        .q_dly_o   (pin_d)
    );

    logic sck_rise;
    logic ld_rise;
    logic s_hd_fall;
    logic s_vd_fall;
    logic sync_fall;
    assign sck_rise  = pin_s[PIN_SCK] & ~pin_d[PIN_SCK];
    assign ld_rise   = pin_s[PIN_SLD_N] & ~pin_d[PIN_SLD_N];
    assign s_hd_fall = ~pin_s[PIN_HD] & pin_d[PIN_HD];
    assign s_vd_fall = ~pin_s[PIN_VD] & pin_d[PIN_VD];
    assign sync_fall = ~pin_s[PIN_VERTICAL_GATE_INPUT] & pin_d[PIN_VERTICAL_GATE_INPUT];

    // ****************************************
    // serial write port
    // ****************************************
    logic [SER_W-1:0] ser_sh;
    logic [5:0]       ser_cnt;
    logic             wr_stb;
    logic [ADDR_W-1:0] wr_addr;
    logic [DATA_W-1:0] wr_data;

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ser_sh  <= '0;
            ser_cnt <= '0;
        end else if (pin_s[PIN_SLD_N]) begin
            ser_cnt <= '0;
        end else if (sck_rise) begin
            ser_sh <= {pin_s[PIN_SDATA], ser_sh[SER_W-1:1]};
            if (ser_cnt != SER_FULL) begin
                ser_cnt <= ser_cnt + 6'h01;
            end
        end
    end

    assign wr_stb  = ld_rise && (ser_cnt == SER_FULL);
    assign wr_addr = ser_sh[ADDR_W-1:0];
    assign wr_data = ser_sh[SER_W-1:ADDR_W];

    // ****************************************
    // control registers
    // ****************************************
    logic [PAT_W-1:0]  pat_sel;
    logic              strobe_en;
    logic              shut_init;
    logic              shut_en;
    logic [POS_W-1:0]  shut_pos;
    logic [FINE_W-1:0] shut_fine;
    logic [LEN_W-1:0]  shut_len;
    logic              slave;

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pat_sel   <= '0;
            strobe_en <= 1'b0;
            shut_init <= 1'b0;
            shut_en   <= 1'b0;
            shut_pos  <= '0;
            shut_fine <= '0;
            shut_len  <= '0;
            slave     <= SLAVE_RST;
        end else if (wr_stb) begin
            unique case (wr_addr)
                ADDR_PAT: pat_sel <= wr_data[PAT_W-1:0];
                ADDR_STROBE: strobe_en <= wr_data[STROBE_BIT];
                ADDR_SHUT: begin
                    shut_init <= wr_data[INIT_BIT];
                    shut_en   <= wr_data[EN_BIT];
                    shut_pos  <= wr_data[POS_LSB +: POS_W];
                    shut_fine <= wr_data[FINE_LSB +: FINE_W];
                end
                ADDR_LEN: shut_len <= wr_data[LEN_W-1:0];
                ADDR_SYNC: slave <= wr_data[SLAVE_BIT];
                default: ;
            endcase
        end
    end

    // ****************************************
    // master sync generator
    // ****************************************
    logic [HCNT_W-1:0] m_h;
    logic [POS_W-1:0]  m_line;
    logic [HCNT_W-1:0] next_m_h;
    logic [POS_W-1:0]  next_m_line;
    logic              next_hd_lvl;
    logic              next_vd_lvl;
    logic              m_hd_fall;
    logic              m_vd_fall;

    always_comb begin
        next_m_h    = m_h + 12'h001;
        next_m_line = m_line;
        if (sync_fall) begin
            next_m_h    = '0;
            next_m_line = '0;
        end else if (m_h == MST_LINE_CYC - 12'h001) begin
            next_m_h    = '0;
            next_m_line = (m_line == MST_FIELD_LINES - 11'h001) ? '0
                                                                : m_line + 11'h001;
        end
    end

    assign next_hd_lvl = (next_m_h >= MST_HD_W);
    assign next_vd_lvl = (next_m_line != '0);
    assign m_hd_fall   = line_sync_o & ~next_hd_lvl;
    assign m_vd_fall   = field_sync_o & ~next_vd_lvl;

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            m_h             <= '0;
            m_line          <= '0;
            line_sync_o     <= 1'b1;
            field_sync_o    <= 1'b1;
            line_sync_oe_o  <= 1'b0;
            field_sync_oe_o <= 1'b0;
        end else begin
            m_h             <= next_m_h;
            m_line          <= next_m_line;
            line_sync_o     <= next_hd_lvl;
            field_sync_o    <= next_vd_lvl;
            line_sync_oe_o  <= ~slave;
            field_sync_oe_o <= ~slave;
        end
    end

    logic hd_ev;
    logic vd_ev;
    logic line_ev;
    assign hd_ev   = slave ? s_hd_fall : m_hd_fall;
    assign vd_ev   = slave ? s_vd_fall : m_vd_fall;
    assign line_ev = hd_ev | vd_ev;

    // ****************************************
    // horizontal gray counter
    // ****************************************
    logic [HCNT_W-1:0] h_bin;
    logic [HCNT_W-1:0] next_h_bin;
    logic [2:0]        hd_tail;

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            hd_tail <= '0;
        end else if (slave && s_hd_fall) begin
            hd_tail <= HD_TAIL;
        end else if (hd_tail != '0) begin
            hd_tail <= hd_tail - 3'h1;
        end
    end

    always_comb begin
        if (!slave) begin
            next_h_bin = next_m_h;
        end else if (hd_tail == 3'h1) begin
            next_h_bin = '0;
        end else begin
            next_h_bin = h_bin + 12'h001;
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            h_bin         <= '0;
            hcount_gray_o <= '0;
        end else begin
            h_bin         <= next_h_bin;
            hcount_gray_o <= next_h_bin ^ (next_h_bin >> 1);
        end
    end

    // ****************************************
    // shutter line sequencer
    // ****************************************
    ssc_shut_e        st;
    ssc_shut_e        cur_st;
    ssc_shut_e        next_st;
    logic [POS_W-1:0] line_cnt;
    logic [POS_W-1:0] next_line;
    logic [LEN_W-1:0] idx;
    logic [LEN_W-1:0] next_idx;
    logic             next_tgt;

    always_comb begin
        next_line = line_cnt;
        next_idx  = idx;
        next_tgt  = 1'b0;
        cur_st    = vd_ev ? SH_ARMED : st;
        next_st   = st;
        if (vd_ev) begin
            next_line = '0;
        end else if (hd_ev && line_cnt != '1) begin
            next_line = line_cnt + 11'h001;
        end
        if (line_ev) begin
            unique case (cur_st)
                SH_ARMED: begin
                    next_st = SH_ARMED;
                    if (next_line == shut_pos && shut_len != '0) begin
                        next_st  = SH_RUN;
                        next_idx = '0;
                        next_tgt = ssc_pat_on(pat_sel, '0, shut_len);
                    end
                end
                SH_RUN: begin
                    if (idx + 8'h01 == shut_len) begin
                        next_st = SH_DONE;
                    end else begin
                        next_idx = idx + 8'h01;
                        next_tgt = ssc_pat_on(pat_sel, idx + 8'h01, shut_len);
                    end
                end
                SH_DONE: next_st = SH_DONE;
                default: next_st = SH_ARMED;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st       <= SH_DONE;
            line_cnt <= '0;
            idx      <= '0;
        end else begin
            st       <= next_st;
            line_cnt <= next_line;
            idx      <= next_idx;
        end
    end

    // ****************************************
    // fine delay and shutter output
    // ****************************************
    logic              pend;
    logic              ptgt;
    logic [FINE_W-1:0] fdly;
    logic [OL_W-1:0]   ol_cnt;
    logic              ol_wrap;
    logic              apply;

    assign ol_wrap = (sub_line_count_length_i == '0)
                  || (ol_cnt >= sub_line_count_length_i - 12'h001);
    assign apply   = pend && (fdly == '0);

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pend   <= 1'b0;
            ptgt   <= 1'b0;
            fdly   <= '0;
            ol_cnt <= '0;
        end else if (line_ev) begin
            pend   <= 1'b1;
            ptgt   <= next_tgt;
            fdly   <= shut_fine;
            ol_cnt <= '0;
        end else if (pend) begin
            if (fdly == '0) begin
                pend <= 1'b0;
            end else if (ol_wrap) begin
                ol_cnt <= '0;
                fdly   <= fdly - 3'h1;
            end else begin
                ol_cnt <= ol_cnt + 12'h001;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mech_shutter_out_o <= 1'b0;
        end else if (shut_init) begin
            mech_shutter_out_o <= 1'b0;
        end else if (shut_en && apply) begin
            mech_shutter_out_o <= ptgt;
        end
    end

    // ****************************************
    // flash trigger
    // ****************************************
    logic substrate_clock_pulse_d;
    logic vsg_d;
    logic substrate_clock_pulse_last_rise;
    logic vsg_fall;

    assign substrate_clock_pulse_last_rise = substrate_clock_pulse_i & ~substrate_clock_pulse_d & substrate_clock_last_i;
    assign vsg_fall        = ~sensor_gate_pulse_i & vsg_d;

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            substrate_clock_pulse_d         <= 1'b0;
            vsg_d           <= 1'b0;
            flash_trigger_o <= 1'b0;
        end else begin
            substrate_clock_pulse_d <= substrate_clock_pulse_i;
            vsg_d   <= sensor_gate_pulse_i;
            if (!strobe_en) begin
                flash_trigger_o <= 1'b0;
            end else if (substrate_clock_pulse_last_rise) begin
                flash_trigger_o <= 1'b1;
            end else if (vsg_fall) begin
                flash_trigger_o <= 1'b0;
            end
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    localparam int A_HRST = HD_TAIL_CYC + 1;

    default clocking a_clk @(posedge clk_sys_i);
    endclocking
    default disable iff (!resetn_i);

    a_init_low: assert property (shut_init |=> !mech_shutter_out_o)
        else $error("shutter not low under initialise");
    a_en_freeze: assert property ((!shut_en && !shut_init) |=> $stable(mech_shutter_out_o))
        else $error("shutter moved while disabled");
    a_fine_zero: assert property ((line_ev && shut_fine == '0 && shut_en && !shut_init
                                   && !next_tgt) ##1 (shut_en && !shut_init)
                                  |=> !mech_shutter_out_o)
        else $error("shutter not low after line fall");
    a_fine_hold: assert property ((pend && fdly != '0 && !shut_init) |=>
                                  $stable(mech_shutter_out_o))
        else $error("shutter moved before fine delay ended");
    a_flash_off: assert property (!strobe_en |=> !flash_trigger_o)
        else $error("flash high while disabled");
    a_flash_set: assert property ((strobe_en && substrate_clock_pulse_last_rise) |=> flash_trigger_o)
        else $error("flash not raised at last substrate pulse");
    a_flash_clr: assert property ((strobe_en && vsg_fall && !substrate_clock_pulse_last_rise)
                                  |=> !flash_trigger_o)
        else $error("flash not cleared at sensor gate");
    a_slave_hreset: assert property ((slave && s_hd_fall) |-> ##A_HRST (h_bin == '0))
        else $error("gray counter not zeroed after line sync");
    a_master_drive: assert property ((!slave ##1 !slave) |->
                                     (line_sync_oe_o && field_sync_oe_o))
        else $error("sync pins not driven in master mode");
    a_start_line: assert property ((st == SH_ARMED && line_ev && !vd_ev && shut_len != '0
                                    && line_cnt + 11'h001 == shut_pos) |=> st == SH_RUN)
        else $error("shutter run not started at position");

    c_shut_high: cover property (!mech_shutter_out_o ##1 mech_shutter_out_o);
    c_flash_pulse: cover property (flash_trigger_o ##1 !flash_trigger_o);
    c_master: cover property (!slave && m_vd_fall);
    c_fine_run: cover property (pend && fdly == 3'h3);

endmodule

`default_nettype wire

//--- testbench/ssc_img_proc.sv
// Purpose: image processor model driving slave line, field and gate
// Assumes: 48-cycle lines, the field start is line 0 of its own
// Notes:   lnum_o and cyc_o give the bench its place in the field

`timescale 1ns/1ps
`default_nettype none

module ssc_img_proc (
    // clock
    input  wire logic       clk_sys_i,
    // control
    input  wire logic       go_i,
    input  wire logic [7:0] lines_i,
    // sync pins
    output logic            line_sync_o,
    output logic            field_sync_o,
    output logic            vertical_gate_o,
    // position
    output logic            busy_o,
    output logic [7:0]      lnum_o,
    output logic [5:0]      cyc_o
);
    initial begin
        line_sync_o = 1'b1;
        field_sync_o = 1'b1;
        vertical_gate_o = 1'b0;
        busy_o = 1'b0;
        lnum_o = 8'h00;
        cyc_o = 6'h00;
        forever begin
            @(negedge clk_sys_i);
            if (go_i === 1'b1) begin
                busy_o <= 1'b1;
                vertical_gate_o <= 1'b1;
                for (int l = 0; l <= lines_i; l++) begin
                    for (int c = 0; c < 48; c++) begin
                        if (l > 0 || c > 0)
                            @(negedge clk_sys_i);
                        lnum_o <= 8'(l);
                        cyc_o <= 6'(c);
                        if (l == 0)
                            field_sync_o <= (c >= 8);
                        else
                            line_sync_o <= (c >= 4);
                    end
                end
                busy_o <= 1'b0;
                vertical_gate_o <= 1'b0;
            end
        end
    end
endmodule

`default_nettype wire

//--- testbench/test_ssc_top.sv
// Purpose: self-checking bench for the shutter, flash and sync block
// Assumes: slave syncs from ssc_img_proc, random sub-line length of 3 to 9 cycles
// Notes:   shutter samples are queued and checked by the monitor

`timescale 1ns/1ps
`default_nettype none

`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
    $display("Error %s expected %h seen %h", n, e, g); end end

module test_ssc_top
    import ssc_pkg::*;
;
    logic              clk_sys_i = 1'b0;
    logic              resetn_i  = 1'b0;
    logic              sdata_i   = 1'b0;
    logic              sck_i     = 1'b0;
    logic              sload_n_i = 1'b1;
    logic              sub_p     = 1'b0;
    logic              sub_last  = 1'b0;
    logic              gate_p    = 1'b0;
    logic              go        = 1'b0;
    logic [7:0]        nlines    = 8'h00;
    logic [11:0]       sub_line_count_length      = 12'h004;
    logic              prev      = 1'b0;
    logic              line_o, line_oe, field_o, field_oe, shut, flash, pl, pf, pg, busy, e;
    logic [HCNT_W-1:0] gray;
    logic [7:0]        lnum;
    logic [5:0]        cyc;
    logic              exp_q[$];
    int                bad_count = 0;
    int                tests_run = 0;
    int                p, l, f;

    always #12.5 clk_sys_i = ~clk_sys_i;

    ssc_img_proc u_proc (.clk_sys_i(clk_sys_i), .go_i(go), .lines_i(nlines),
        .line_sync_o(pl), .field_sync_o(pf), .vertical_gate_o(pg), .busy_o(busy),
        .lnum_o(lnum), .cyc_o(cyc));

    ssc_top dut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .sdata_i(sdata_i),
        .sck_i(sck_i), .sload_n_i(sload_n_i), .line_sync_i(line_oe ? line_o : pl),
        .line_sync_o(line_o), .line_sync_oe_o(line_oe),
        .field_sync_i(field_oe ? field_o : pf), .field_sync_o(field_o),
        .field_sync_oe_o(field_oe), .vertical_gate_input_i(pg),
        .substrate_clock_pulse_i(sub_p), .substrate_clock_last_i(sub_last),
        .sensor_gate_pulse_i(gate_p), .sub_line_count_length_i(sub_line_count_length),
        .mech_shutter_out_o(shut), .flash_trigger_o(flash), .hcount_gray_o(gray));

    task automatic stop_test();
        if (bad_count == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // ****************************************
    // serial writes and field runs
    // ****************************************
    task automatic wr(input logic [7:0] a, input logic [23:0] d, input int n = 32);
        logic [31:0] fr;
        fr = {d, a};
        @(negedge clk_sys_i);
        sload_n_i = 1'b0;
        for (int i = 0; i < n; i++) begin
            sdata_i = fr[i];
            repeat (4) @(negedge clk_sys_i);
            sck_i = 1'b1;
            repeat (4) @(negedge clk_sys_i);
            sck_i = 1'b0;
        end
        repeat (4) @(negedge clk_sys_i);
        sload_n_i = 1'b1;
        repeat (6) @(negedge clk_sys_i);
    endtask

    function automatic logic on_at(int k, int ps, int ln, int s);
        int i;
        i = k - ps;
        if (i < 0 || i >= ln)
            return 1'b0;
        case (s)
            1: return i < ln / 2;
            2: return i >= ln / 2;
            3: return i != 0;
            default: return 1'b1;
        endcase
    endfunction

    // early sample sees the old level while a fine delay is pending
    task automatic run(int n, int ps, int ln, int s, int fd);
        logic cur;
        for (int k = 0; k <= n; k++) begin
            cur = on_at(k, ps, ln, s);
            exp_q.push_back(fd != 0 ? prev : cur);
            exp_q.push_back(cur);
            prev = cur;
        end
        nlines <= 8'(n);
        go <= 1'b1;
        for (int i = 0; i < 8 && busy !== 1'b1; i++)
            @(negedge clk_sys_i);
        go <= 1'b0;
        for (int i = 0; i < 20000 && busy !== 1'b0; i++)
            @(negedge clk_sys_i);
        if (busy !== 1'b0) begin
            bad_count++;
            stop_test();
        end
    endtask

    task automatic ev(input logic s, input logic g, input logic lst);
        sub_p = s;
        gate_p = g;
        sub_last = lst;
        repeat (3) @(negedge clk_sys_i);
    endtask

    // ****************************************
    // monitor
    // ****************************************
    always @(negedge clk_sys_i) begin
        if (busy === 1'b1 && (cyc == 6'd11 || cyc == 6'd34)) begin
            e = exp_q.size() ? exp_q.pop_front() : 1'bx;
            `CHK("mech_shutter_out_o", e, shut)
        end
        if (busy === 1'b1 && lnum != 8'h00 && cyc == 6'd6)
            `CHK("hcount_gray_o", 12'h000, gray)
        if (busy === 1'b1 && lnum != 8'h00 && cyc == 6'd9)
            `CHK("hcount_gray_o", 12'h002, gray)
    end

    initial begin
        void'($urandom(32'h858BEA5F));
        repeat (3) @(negedge clk_sys_i);
        resetn_i = 1'b1;
        `CHK("mech_shutter_out_o", 1'b0, shut)
        `CHK("line_sync_oe_o", 1'b0, line_oe)
        `CHK("field_sync_oe_o", 1'b0, field_oe)
        wr(ADDR_LEN, 24'h000008);
        wr(ADDR_SHUT, 24'h000002);
        run(3, 0, 255, 0, 0);
        // short frame and unmapped address leave the freeze in place
        wr(ADDR_SHUT, 24'h000000);
        wr(ADDR_SHUT, 24'h000003, 31);
        wr(8'h55, 24'hFFFFFF);
        run(10, 0, 255, 0, 0);
        wr(ADDR_SHUT, 24'h000003);
        run(2, 0, 0, 0, 0);
        for (int s = 0; s < 4; s++) begin
            p = $urandom_range(3);
            l = $urandom_range(6, 2);
            f = (s % 2) * 3;
            sub_line_count_length = 12'($urandom_range(9, 3));
            wr(ADDR_LEN, 24'(l));
            wr(ADDR_PAT, 24'(s));
            wr(ADDR_SHUT, {8'h00, 3'(f), 11'(p), 2'b10});
            run(p + l + 2, p, l, s, f);
        end
        ev(1'b1, 1'b0, 1'b1);
        ev(1'b0, 1'b0, 1'b0);
        `CHK("flash_trigger_o", 1'b0, flash)
        wr(ADDR_STROBE, 24'h000002);
        ev(1'b1, 1'b0, 1'b0);
        ev(1'b0, 1'b0, 1'b0);
        `CHK("flash_trigger_o", 1'b0, flash)
        ev(1'b1, 1'b0, 1'b1);
        `CHK("flash_trigger_o", 1'b1, flash)
        ev(1'b0, 1'b1, 1'b0);
        `CHK("flash_trigger_o", 1'b1, flash)
        ev(1'b0, 1'b0, 1'b0);
        `CHK("flash_trigger_o", 1'b0, flash)
        ev(1'b1, 1'b0, 1'b1);
        ev(1'b0, 1'b0, 1'b0);
        wr(ADDR_STROBE, 24'h000000);
        `CHK("flash_trigger_o", 1'b0, flash)
        wr(ADDR_SYNC, 24'h000000);
        `CHK("line_sync_oe_o", 1'b1, line_oe)
        `CHK("field_sync_oe_o", 1'b1, field_oe)
        for (int i = 0; i < 2000 && line_o !== 1'b0; i++)
            @(negedge clk_sys_i);
        `CHK("line_sync_o", 1'b0, line_o)
        // gate fall restarts the master line and field counters
        run(0, 0, 0, 0, 0);
        repeat (4) @(negedge clk_sys_i);
        `CHK("field_sync_o", 1'b0, field_o)
        `CHK("line_sync_o", 1'b0, line_o)
        `CHK("expected queue", 0, exp_q.size())
        stop_test();
    end
endmodule

`default_nettype wire
